// >>> rtl/cbcr_consts.vh
`ifndef CBCR_CONSTS_VH
`define CBCR_CONSTS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CBCR_OFS_PLL_CTRL   8'h00
`define CBCR_OFS_PAIR_EN    8'h01
`define CBCR_OFS_SPARE_TWO  8'h02
`define CBCR_OFS_SPARE_THR  8'h03
`define CBCR_OFS_VENDOR_ID  8'h04
`define CBCR_REG_COUNT      8'h05

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CBCR_BIT_PLL_PATH   1
`define CBCR_BIT_LOOP_BW    2
`define CBCR_BIT_POWERDOWN_DRIVE_MODE    7
`define CBCR_BIT_EN_PAIR0   1
`define CBCR_BIT_EN_PAIR1   2
`define CBCR_BIT_EN_PAIR2   5
`define CBCR_BIT_EN_PAIR3   6

// ---------------------------------------------------------------
// writable masks and reset values
// ---------------------------------------------------------------
`define CBCR_MASK_PLL_CTRL  8'h86
`define CBCR_MASK_PAIR_EN   8'h66
`define CBCR_MASK_SPARE_THR 8'hFF
`define CBCR_RST_PLL_CTRL   8'h06
`define CBCR_RST_PAIR_EN    8'h66
`define CBCR_RST_SPARE_THR  8'h00

// ---------------------------------------------------------------
// bus address and identification
// ---------------------------------------------------------------
`define CBCR_SLAVE_ADDR     7'h6E
// arbitrary value, not a real maker code
`define CBCR_VENDOR_ID      8'h5A

// ---------------------------------------------------------------
// output pair drive codes
// ---------------------------------------------------------------
`define CBCR_PAIR_LOW       2'b00
`define CBCR_PAIR_PARK      2'b01
`define CBCR_PAIR_CLOCK     2'b10

`endif

// >>> rtl/cbcr_sync.v
`timescale 1ns/1ps

module cbcr_sync #(
    parameter WIDTH = 3
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] asyncIn,
    input  wire [WIDTH-1:0] rstVal,
    output reg  [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_q;

    // rstVal only loads after release; async reset takes constants only
    reg armed_q;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q  <= {WIDTH{1'b1}};
            syncOut <= {WIDTH{1'b1}};
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
            meta_q  <= asyncIn;
            syncOut <= armed_q ? meta_q : rstVal;
        end
    end

endmodule

// >>> rtl/cbcr_clock_buffer_regs.v
// Function
// - byte0 bit1 selects fanout or PLL, reset PLL
// - byte0 bit2 bandwidth select, reset low bandwidth
// - byte0 bit7 powerdown drive mode, reset zero
// - byte1 bits 1,2,5,6 enable pairs 0..3
// - byte2 reserved, reads zero, no effect
// - byte3 stores all bits, no effect
// - byte4 fixed vendor code, writes ignored
// - slave block read/write: offset, count, data
// - no register access while powerdown asserted
// - answer one fixed seven-bit address only
`timescale 1ns/1ps
`include "cbcr_consts.vh"

module cbcr_clock_buffer_regs (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       sclIn,
    input  wire       sdaIn,
    input  wire       powerdown_n,
    output reg        sdaOut,
    output reg        sdaOe,
    output reg        pllPathSelect,
    output reg        loop_bandwidth_select,
    output reg        powerdown_drive_mode,
    output reg  [7:0] pairState
);

    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_CMD  = 3'd2;
    localparam [2:0] ST_CNT  = 3'd3;
    localparam [2:0] ST_WDAT = 3'd4;
    localparam [2:0] ST_RCNT = 3'd5;
    localparam [2:0] ST_RDAT = 3'd6;
    localparam [2:0] ST_IGN  = 3'd7;

    localparam [7:0] REG_COUNT = `CBCR_REG_COUNT;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire [2:0] pinSync;

    cbcr_sync #(
        .WIDTH (3)
    ) uSync (
        .core_clk (core_clk),
        .rst      (rst),
        .asyncIn  ({powerdown_n, sdaIn, sclIn}),
        .rstVal   (3'b111),
        .syncOut  (pinSync)
    );

    wire sclS  = pinSync[0];
    wire sdaS  = pinSync[1];
    wire pdOkS = pinSync[2];

    reg sclPrev_q;
    reg sdaPrev_q;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    wire sclRise  = sclS & ~sclPrev_q;
    wire sclFall  = ~sclS & sclPrev_q;
    wire startCnd = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    wire stopCnd  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    reg [7:0] pllCtrl_q;
    reg [7:0] pairEn_q;
    reg [7:0] spareThr_q;

    function [7:0] rdMux;
        input [7:0] ofs;
        input [7:0] b0;
        input [7:0] b1;
        input [7:0] b3;
        begin
            case (ofs)
                `CBCR_OFS_PLL_CTRL:  rdMux = b0 & `CBCR_MASK_PLL_CTRL;
                `CBCR_OFS_PAIR_EN:   rdMux = b1 & `CBCR_MASK_PAIR_EN;
                `CBCR_OFS_SPARE_TWO: rdMux = 8'h00;
                `CBCR_OFS_SPARE_THR: rdMux = b3;
                `CBCR_OFS_VENDOR_ID: rdMux = `CBCR_VENDOR_ID;
                default:             rdMux = 8'h00;
            endcase
        end
    endfunction

    function [7:0] mergeW;
        input [7:0] old;
        input [7:0] wr;
        input [7:0] mask;
        begin
            mergeW = (old & ~mask) | (wr & mask);
        end
    endfunction

    // ---------------------------------------------------------------
    // serial slave
    // ---------------------------------------------------------------
    reg [2:0] state_q;
    reg [3:0] bitCnt_q;
    reg       ackPhase_q;
    reg       hostAck_q;
    reg [7:0] rxSh_q;
    reg [7:0] txSh_q;
    reg [7:0] idx_q;
    reg [7:0] remain_q;

    wire txMode = (state_q == ST_RCNT) || (state_q == ST_RDAT);
    wire [7:0] rdByte = rdMux(idx_q, pllCtrl_q, pairEn_q, spareThr_q);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            bitCnt_q   <= 4'h0;
            ackPhase_q <= 1'b0;
            hostAck_q  <= 1'b0;
            rxSh_q     <= 8'h00;
            txSh_q     <= 8'h00;
            idx_q      <= 8'h00;
            remain_q   <= 8'h00;
            sdaOe      <= 1'b0;
            sdaOut     <= 1'b0;
            pllCtrl_q  <= `CBCR_RST_PLL_CTRL;
            pairEn_q   <= `CBCR_RST_PAIR_EN;
            spareThr_q <= `CBCR_RST_SPARE_THR;
        end else if (!pdOkS) begin
            // bus is dead while powered down; release the line
            state_q    <= ST_IDLE;
            ackPhase_q <= 1'b0;
            sdaOe      <= 1'b0;
        end else if (startCnd) begin
            // start or repeated start: keep offset for block read
            state_q    <= ST_ADDR;
            bitCnt_q   <= 4'h0;
            ackPhase_q <= 1'b0;
            sdaOe      <= 1'b0;
        end else if (stopCnd) begin
            state_q    <= ST_IDLE;
            ackPhase_q <= 1'b0;
            sdaOe      <= 1'b0;
        end else if (state_q != ST_IDLE && state_q != ST_IGN) begin
            if (sclRise) begin
                if (ackPhase_q) begin
                    hostAck_q <= ~sdaS;
                end else if (bitCnt_q != 4'h8) begin
                    rxSh_q   <= {rxSh_q[6:0], sdaS};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
            end else if (sclFall) begin
                if (ackPhase_q) begin
                    ackPhase_q <= 1'b0;
                    bitCnt_q   <= 4'h0;
                    if (state_q == ST_RCNT) begin
                        // address acked: count first; a nack on it ends the read
                        txSh_q  <= REG_COUNT;
                        sdaOe   <= ~REG_COUNT[7];
                        state_q <= ST_RDAT;
                    end else if (txMode) begin
                        if (hostAck_q) begin
                            txSh_q  <= rdByte;
                            sdaOe   <= ~rdByte[7];
                            idx_q   <= idx_q + 8'h01;
                        end else begin
                            sdaOe   <= 1'b0;
                            state_q <= ST_IGN;
                        end
                    end else begin
                        sdaOe <= 1'b0;
                    end
                end else if (txMode) begin
                    if (bitCnt_q == 4'h8) begin
                        sdaOe      <= 1'b0;
                        ackPhase_q <= 1'b1;
                    end else begin
                        sdaOe  <= ~txSh_q[6];
                        txSh_q <= {txSh_q[6:0], 1'b0};
                    end
                end else if (bitCnt_q == 4'h8) begin
                    case (state_q)
                        ST_ADDR: begin
                            if (rxSh_q[7:1] == `CBCR_SLAVE_ADDR) begin
                                sdaOe      <= 1'b1;
                                ackPhase_q <= 1'b1;
                                hostAck_q  <= 1'b0;
                                txSh_q     <= 8'h00;
                                state_q    <= rxSh_q[0] ? ST_RCNT : ST_CMD;
                            end else begin
                                state_q <= ST_IGN;
                            end
                        end
                        ST_CMD: begin
                            idx_q      <= rxSh_q;
                            sdaOe      <= 1'b1;
                            ackPhase_q <= 1'b1;
                            state_q    <= ST_CNT;
                        end
                        ST_CNT: begin
                            // a zero count simply stores nothing
                            remain_q   <= rxSh_q;
                            sdaOe      <= 1'b1;
                            ackPhase_q <= 1'b1;
                            state_q    <= ST_WDAT;
                        end
                        ST_WDAT: begin
                            if (remain_q != 8'h00) begin
                                case (idx_q)
                                    `CBCR_OFS_PLL_CTRL:
                                        pllCtrl_q <= mergeW(pllCtrl_q, rxSh_q,
                                                            `CBCR_MASK_PLL_CTRL);
                                    `CBCR_OFS_PAIR_EN:
                                        pairEn_q <= mergeW(pairEn_q, rxSh_q,
                                                           `CBCR_MASK_PAIR_EN);
                                    `CBCR_OFS_SPARE_THR:
                                        spareThr_q <= mergeW(spareThr_q, rxSh_q,
                                                             `CBCR_MASK_SPARE_THR);
                                    default: ;
                                endcase
                                idx_q      <= idx_q + 8'h01;
                                remain_q   <= remain_q - 8'h01;
                                sdaOe      <= 1'b1;
                                ackPhase_q <= 1'b1;
                            end else begin
                                state_q <= ST_IGN;
                            end
                        end
                        default: state_q <= ST_IGN;
                    endcase
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // clock output control
    // ---------------------------------------------------------------
    function [1:0] pairCode;
        input en;
        input pdOk;
        input mode;
        begin
            if (!en)
                pairCode = `CBCR_PAIR_LOW;
            else if (pdOk)
                pairCode = `CBCR_PAIR_CLOCK;
            else if (mode)
                pairCode = `CBCR_PAIR_LOW;
            else
                pairCode = `CBCR_PAIR_PARK;
        end
    endfunction

    wire pdMode = pllCtrl_q[`CBCR_BIT_POWERDOWN_DRIVE_MODE];

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pllPathSelect         <= 1'b1;
            loop_bandwidth_select <= 1'b1;
            powerdown_drive_mode  <= 1'b0;
            pairState             <= {4{`CBCR_PAIR_CLOCK}};
        end else begin
            pllPathSelect         <= pllCtrl_q[`CBCR_BIT_PLL_PATH];
            loop_bandwidth_select <= pllCtrl_q[`CBCR_BIT_LOOP_BW];
            powerdown_drive_mode  <= pdMode;
            pairState[1:0] <= pairCode(pairEn_q[`CBCR_BIT_EN_PAIR0], pdOkS, pdMode);
            pairState[3:2] <= pairCode(pairEn_q[`CBCR_BIT_EN_PAIR1], pdOkS, pdMode);
            pairState[5:4] <= pairCode(pairEn_q[`CBCR_BIT_EN_PAIR2], pdOkS, pdMode);
            pairState[7:6] <= pairCode(pairEn_q[`CBCR_BIT_EN_PAIR3], pdOkS, pdMode);
        end
    end

endmodule

// >>> testbench/cbcr_smb_host.sv
`timescale 1ns/1ps

module cbcr_smb_host #(
    parameter [6:0] ADDR = 7'h00,
    parameter       PH   = 8
) (
    input  wire core_clk,
    input  wire sdaLine,
    output reg  scl,
    output reg  sdaDrv
);
    reg [7:0] ackLog;
    reg [7:0] rdBuf [0:7];

    // ----------------------------------------
    // bus phases, each well above the 4-clock floor
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
        ackLog = 8'h00;
    end

    task ph;
        repeat (PH) @(posedge core_clk);
    endtask

    task bitOut(input b);
        begin
            sdaDrv <= b;
            ph;
            scl <= 1'b1;
            ph;
            scl <= 1'b0;
            ph;
        end
    endtask

    task bitIn(output b);
        begin
            sdaDrv <= 1'b1;
            ph;
            scl <= 1'b1;
            ph;
            b = sdaLine;
            scl <= 1'b0;
            ph;
        end
    endtask

    // also serves as repeated start
    task startCond;
        begin
            sdaDrv <= 1'b1;
            ph;
            scl <= 1'b1;
            ph;
            sdaDrv <= 1'b0;
            ph;
            scl <= 1'b0;
            ph;
        end
    endtask

    task stopCond;
        begin
            sdaDrv <= 1'b0;
            ph;
            scl <= 1'b1;
            ph;
            sdaDrv <= 1'b1;
            ph;
        end
    endtask

    task byteOut(input [7:0] d);
        integer i;
        reg     a;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bitOut(d[i]);
            end
            bitIn(a);
            ackLog = {ackLog[6:0], ~a};
        end
    endtask

    task byteIn(input integer k, input ackIt);
        integer   i;
        reg       b;
        reg [7:0] v;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                bitIn(b);
                v = {v[6:0], b};
            end
            rdBuf[k] = v;
            bitOut(~ackIt);
        end
    endtask

    task wrBytes(input [6:0] addr, input [7:0] ofs, input [7:0] cnt,
                 input [7:0] d0, input [7:0] d1, input [7:0] d2, input integer nd);
        begin
            ackLog = 8'h00;
            startCond;
            byteOut({addr, 1'b0});
            byteOut(ofs);
            byteOut(cnt);
            if (nd > 0) byteOut(d0);
            if (nd > 1) byteOut(d1);
            if (nd > 2) byteOut(d2);
            stopCond;
        end
    endtask

    task rdBytes(input [7:0] ofs, input integer n);
        integer k;
        begin
            startCond;
            byteOut({ADDR, 1'b0});
            byteOut(ofs);
            startCond;
            byteOut({ADDR, 1'b1});
            for (k = 0; k <= n; k = k + 1) begin
                byteIn(k, k < n);
            end
            stopCond;
        end
    endtask
endmodule

// >>> testbench/cbcr_regs_checker.sv
`timescale 1ns/1ps

module cbcr_regs_checker (
    input wire       core_clk,
    input wire       rst,
    input wire       sclIn,
    input wire       sdaIn,
    input wire       powerdown_n,
    input wire       sdaOut,
    input wire       sdaOe,
    input wire       pllPathSelect,
    input wire       loop_bandwidth_select,
    input wire       powerdown_drive_mode,
    input wire [7:0] pairState
);
    wire [2:0] cfgBits = {powerdown_drive_mode, loop_bandwidth_select, pllPathSelect};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence sclFall;
        sclIn ##1 !sclIn;
    endsequence
    sequence sclLowTail;
        !sclIn [*3];
    endsequence

    open_drain_a: assert property (sdaOut == 1'b0)
        else $error("data output driven high");
    reset_values_a: assert property ($fell(rst) |-> pairState == 8'hAA
        && pllPathSelect && loop_bandwidth_select && !powerdown_drive_mode && !sdaOe)
        else $error("wrong state at reset release");
    ack_settle_a: assert property ((sclFall ##5 sclLowTail) |-> $stable(sdaOe))
        else $error("data drive moved late in low phase");
    high_hold_a: assert property (sclIn [*4] |-> $stable(sdaOe))
        else $error("data drive moved while clock high");
    pd_no_ack_a: assert property (!powerdown_n [*5] |-> !sdaOe)
        else $error("bus answered during power-down");
    cfg_hold_pd_a: assert property (!powerdown_n [*3] |-> $stable(cfgBits))
        else $error("config changed during power-down");
    pd_drive_a: assert property (!powerdown_n [*5] |->
        (pairState & (powerdown_drive_mode ? 8'hFF : 8'hAA)) == 8'h00)
        else $error("pair drive wrong in power-down");
    run_clock_a: assert property (powerdown_n [*5] |-> (pairState & 8'h55) == 8'h00)
        else $error("pair parked while running");
    cfg_timing_a: assert property ($changed(cfgBits) |-> !sclIn && !$past(sclIn))
        else $error("config changed outside clock low");
endmodule

bind cbcr_clock_buffer_regs cbcr_regs_checker u_cbcr_regs_checker (
    .core_clk(core_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .powerdown_n(powerdown_n), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .pllPathSelect(pllPathSelect), .loop_bandwidth_select(loop_bandwidth_select),
    .powerdown_drive_mode(powerdown_drive_mode), .pairState(pairState)
);

// >>> testbench/cbcr_clock_buffer_regs_tb.sv
`timescale 1ns/1ps
`include "cbcr_consts.vh"

module cbcr_clock_buffer_regs_tb;
    reg        core_clk;
    reg        rst;
    reg        powerdown_n;
    wire       scl;
    wire       hostSda;
    wire       sdaLine;
    wire       sdaOut;
    wire       sdaOe;
    wire       pllPathSelect;
    wire       loopBw;
    wire       pdMode;
    wire [7:0] pairState;
    integer    num_errors;
    integer    compares;
    integer    r;
    reg [39:0] rows [0:7];
    reg [47:0] expRst;

    // pull-up on the data line, device only pulls low
    assign sdaLine = hostSda & (sdaOe ? sdaOut : 1'b1);

    cbcr_clock_buffer_regs u_cbcr_clock_buffer_regs (
        .core_clk(core_clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine),
        .powerdown_n(powerdown_n), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .pllPathSelect(pllPathSelect), .loop_bandwidth_select(loopBw),
        .powerdown_drive_mode(pdMode), .pairState(pairState)
    );

    cbcr_smb_host #(.ADDR(`CBCR_SLAVE_ADDR), .PH(8)) u_cbcr_smb_host (
        .core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(hostSda)
    );

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    task chkByte(input string name, input [7:0] exp, input [7:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                $display("unexpected %s: expected %h seen %h", name, exp, got);
                num_errors = num_errors + 1;
            end
        end
    endtask

    task chkOut(input [7:0] cfg, input [7:0] pairs);
        begin
            chkByte("config", cfg, {5'h00, pdMode, loopBw, pllPathSelect});
            chkByte("pairs", pairs, pairState);
        end
    endtask

    task wr(input [6:0] a, input [7:0] ofs, input [7:0] d);
        u_cbcr_smb_host.wrBytes(a, ofs, 8'h01, d, 8'h00, 8'h00, 1);
    endtask

    task pdWait(input v);
        begin
            powerdown_n <= v;
            repeat (10) @(posedge core_clk);
        end
    endtask

    task end_sim;
        begin
            $display("compares %0d num_errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        $display("unexpected run length: limit reached");
        num_errors = num_errors + 1;
        end_sim;
    end

    initial begin
        rst = 1'b1;
        powerdown_n = 1'b1;
        num_errors = 0;
        compares = 0;
        // offset, write data, readback, config, pairs
        rows[0] = {8'h00, 8'hFF, 8'h86, 8'h07, 8'hAA};
        rows[1] = {8'h00, 8'h00, 8'h00, 8'h00, 8'hAA};
        rows[2] = {8'h01, 8'h99, 8'h00, 8'h00, 8'h00};
        rows[3] = {8'h01, 8'h24, 8'h24, 8'h00, 8'h28};
        rows[4] = {8'h02, 8'hFF, 8'h00, 8'h00, 8'h28};
        rows[5] = {8'h03, 8'hA5, 8'hA5, 8'h00, 8'h28};
        rows[6] = {8'h04, 8'h00, `CBCR_VENDOR_ID, 8'h00, 8'h28};
        rows[7] = {8'h05, 8'h77, 8'h00, 8'h00, 8'h28};
        expRst = {8'h05, 8'h06, 8'h66, 8'h00, 8'h00, `CBCR_VENDOR_ID};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        chkOut(8'h03, 8'hAA);
        u_cbcr_smb_host.rdBytes(8'h00, 5);
        for (r = 0; r < 6; r = r + 1) begin
            chkByte("reset read", expRst[47-8*r -: 8], u_cbcr_smb_host.rdBuf[r]);
        end
        for (r = 0; r < 8; r = r + 1) begin
            wr(`CBCR_SLAVE_ADDR, rows[r][39:32], rows[r][31:24]);
            u_cbcr_smb_host.rdBytes(rows[r][39:32], 1);
            chkByte("count", 8'h05, u_cbcr_smb_host.rdBuf[0]);
            chkByte("readback", rows[r][23:16], u_cbcr_smb_host.rdBuf[1]);
            chkOut(rows[r][15:8], rows[r][7:0]);
        end
        // ----------------------------------------
        // awkward cases
        // ----------------------------------------
        u_cbcr_smb_host.wrBytes(`CBCR_SLAVE_ADDR, 8'h00, 8'h02, 8'h04, 8'h42, 8'hFF, 3);
        chkByte("acks", 8'h3E, u_cbcr_smb_host.ackLog);
        chkOut(8'h02, 8'h82);
        u_cbcr_smb_host.rdBytes(8'h01, 2);
        chkByte("incr read", 8'h42, u_cbcr_smb_host.rdBuf[1]);
        chkByte("incr read", 8'h00, u_cbcr_smb_host.rdBuf[2]);
        wr(7'h37, 8'h00, 8'h00);
        chkByte("foreign acks", 8'h00, u_cbcr_smb_host.ackLog);
        chkOut(8'h02, 8'h82);
        pdWait(1'b0);
        chkOut(8'h02, 8'h41);
        // deliberate access while powered down, must be refused
        wr(`CBCR_SLAVE_ADDR, 8'h00, 8'h80);
        chkByte("pd acks", 8'h00, u_cbcr_smb_host.ackLog);
        pdWait(1'b1);
        chkOut(8'h02, 8'h82);
        wr(`CBCR_SLAVE_ADDR, 8'h00, 8'h84);
        pdWait(1'b0);
        chkOut(8'h06, 8'h00);
        pdWait(1'b1);
        chkOut(8'h06, 8'h82);
        // ----------------------------------------
        // mid-run reset with the bus idle
        // ----------------------------------------
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        chkOut(8'h03, 8'hAA);
        u_cbcr_smb_host.rdBytes(8'h00, 0);
        chkByte("nack count", 8'h05, u_cbcr_smb_host.rdBuf[0]);
        u_cbcr_smb_host.rdBytes(8'h00, 4);
        for (r = 1; r < 5; r = r + 1) begin
            chkByte("reset read", expRst[47-8*r -: 8], u_cbcr_smb_host.rdBuf[r]);
        end
        end_sim;
    end
endmodule
